//--- src/dss_scaler.sv
// digital setpoint scaler: word decode, bias/gain scaling, torque and source ranking
// Notes on behaviour
// - gain setting 9999 makes the decoded word itself the frequency setpoint
// - direct mode leaves that format's bias unused
// - zero input yields the bias frequency of its own format
// - full-scale input yields the gain frequency of its own format
// - direct mode multiplies by unit step: 10, 1, 0.1 or 0.01 Hz
// - unit step ignored unless gain holds 9999
// - torque accepted only for method 4 or 14 with torque source 4
// - torque magnitude is low 15 or 11 bits, top bit is sign
// - torque words decode as binary only
// - torque selection disables the unit step setting
// - magnitude zero gives torque bias, full magnitude gives torque gain
// - sign bit gives the mirrored negative torque command
// - torque gain 9999 takes magnitude directly as percent
// - direct torque magnitude above h190 clamps to 400 percent
// - bcd word with a digit a..f is ignored; previous word kept
// - switching binary to bcd with an invalid digit forces zero frequency
// - source rank: jog, stop, multi-speed, pid, current, pulse, digital, voltage
// - voltage analog input ignored while the digital setpoint is valid
// - binary words read as hexadecimal, bcd words as decimal digits
// - methods 0 to 4 ignore the four upper input lines
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module dss_scaler (
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    input  wire dss_pkg::dss_bus_req_t bus_req,
    output var  logic [31:0]           rdata,
    input  wire logic [15:0]           setpoint_input_lines,
    input  wire dss_pkg::dss_src_req_t src_req,
    output var  logic [27:0]           freq_setpoint,
    output var  logic signed [9:0]     torque_cmd,
    output var  logic                  torque_valid,
    output var  logic                  digital_valid,
    output var  logic                  analog_comp_enable,
    output var  logic [7:0]            active_source
);

    // settings
    logic [15:0] bcd_bias_freq_q;
    logic [15:0] bcd_gain_freq_q;
    logic [15:0] bin_bias_freq_q;
    logic [15:0] bin_gain_freq_q;
    logic [15:0] input_method_select_q;
    logic [1:0]  direct_unit_step_q;
    logic [15:0] torque_bias_pct_q;
    logic [15:0] torque_gain_pct_q;
    logic [2:0]  torque_source_select_q;

    // input state
    logic [15:0] word_q;
    logic        was_bcd_q;
    logic        force_zero_q;
    logic        reject_q;

    // output registers
    logic [27:0]        freq_q;
    logic signed [9:0]  torque_q;
    logic               torque_valid_q;
    logic               digital_valid_q;
    logic               comp_q;
    logic [7:0]         source_q;
    logic [31:0]        rdata_q;

    function automatic logic [15:0] bcd_value(input logic [15:0] w);
        bcd_value = 16'(w[15:12] * 16'd1000) + 16'(w[11:8] * 16'd100)
                  + 16'(w[7:4] * 16'd10) + 16'(w[3:0]);
    endfunction : bcd_value

    function automatic logic bcd_bad(input logic [15:0] w, input logic four);
        bcd_bad = (w[3:0] > 4'h9) || (w[7:4] > 4'h9) || (w[11:8] > 4'h9)
                || (four && (w[15:12] > 4'h9));
    endfunction : bcd_bad

    // linear map from bias at zero to gain at full scale
    function automatic logic [27:0] interp(input logic [15:0] bias, input logic [15:0] gain,
                                           input logic [16:0] val, input logic [16:0] fs);
        logic signed [17:0] diff;
        logic signed [35:0] prod;
        logic signed [35:0] quo;
        diff   = $signed({2'b00, gain}) - $signed({2'b00, bias});
        prod   = 36'(diff * $signed({1'b0, val}));
        quo    = prod / $signed({19'h00000, fs});
        interp = 28'($signed({20'h00000, bias}) + quo);
    endfunction : interp

    // method decode
    logic [15:0] meth;
    logic        m_bcd;
    logic        m_bin;
    logic        m_trq;
    logic        m_wide;
    logic        m_comp;
    always_comb begin
        meth   = input_method_select_q;
        m_bcd  = (meth == dss_pkg::METH_BCD3) || (meth == dss_pkg::METH_BCD3_COMP)
              || (meth == dss_pkg::METH_BCD4) || (meth == dss_pkg::METH_BCD4_COMP);
        m_bin  = (meth == dss_pkg::METH_BIN12) || (meth == dss_pkg::METH_BIN12_COMP)
              || (meth == dss_pkg::METH_BIN16) || (meth == dss_pkg::METH_BIN16_COMP);
        m_trq  = (meth == dss_pkg::METH_TRQ12) || (meth == dss_pkg::METH_TRQ16);
        m_wide = (meth >= dss_pkg::METH_BCD4) && (meth <= dss_pkg::METH_TRQ16);
        m_comp = (meth == dss_pkg::METH_BCD3_COMP) || (meth == dss_pkg::METH_BIN12_COMP)
              || (meth == dss_pkg::METH_BCD4_COMP) || (meth == dss_pkg::METH_BIN16_COMP);
    end

    // upper lines dropped in the narrow methods
    logic [15:0] lines;
    logic        lines_bad;
    always_comb begin
        lines     = m_wide ? setpoint_input_lines
                           : {4'h0, setpoint_input_lines[11:0]};
        lines_bad = m_bcd && bcd_bad(lines, m_wide);
    end

    // register writes
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bcd_bias_freq_q        <= dss_pkg::RST_BIAS_FREQ;
            bcd_gain_freq_q        <= dss_pkg::RST_GAIN_FREQ;
            bin_bias_freq_q        <= dss_pkg::RST_BIAS_FREQ;
            bin_gain_freq_q        <= dss_pkg::RST_GAIN_FREQ;
            input_method_select_q  <= dss_pkg::RST_METHOD;
            direct_unit_step_q     <= dss_pkg::RST_UNIT_STEP;
            torque_bias_pct_q      <= dss_pkg::RST_TRQ_BIAS;
            torque_gain_pct_q      <= dss_pkg::RST_TRQ_GAIN;
            torque_source_select_q <= dss_pkg::RST_TRQ_SOURCE;
        end else if (bus_req.wr) begin
            unique case (bus_req.addr)
                dss_pkg::ADDR_BCD_BIAS:   bcd_bias_freq_q        <= bus_req.wdata[15:0];
                dss_pkg::ADDR_BCD_GAIN:   bcd_gain_freq_q        <= bus_req.wdata[15:0];
                dss_pkg::ADDR_BIN_BIAS:   bin_bias_freq_q        <= bus_req.wdata[15:0];
                dss_pkg::ADDR_BIN_GAIN:   bin_gain_freq_q        <= bus_req.wdata[15:0];
                dss_pkg::ADDR_METHOD:     input_method_select_q  <= bus_req.wdata[15:0];
                dss_pkg::ADDR_UNIT_STEP:  direct_unit_step_q     <= bus_req.wdata[1:0];
                dss_pkg::ADDR_TRQ_BIAS:   torque_bias_pct_q      <= bus_req.wdata[15:0];
                dss_pkg::ADDR_TRQ_GAIN:   torque_gain_pct_q      <= bus_req.wdata[15:0];
                dss_pkg::ADDR_TRQ_SOURCE: torque_source_select_q <= bus_req.wdata[2:0];
                default: ;
            endcase
        end
    end

    // accepted input word
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            word_q       <= 16'h0000;
            was_bcd_q    <= 1'b0;
            force_zero_q <= 1'b0;
            reject_q     <= 1'b0;
        end else begin
            was_bcd_q <= m_bcd;
            reject_q  <= lines_bad;
            if (!lines_bad) begin
                word_q       <= lines;
                force_zero_q <= 1'b0;
            end else if (!was_bcd_q && m_bcd) begin
                force_zero_q <= 1'b1;
            end
        end
    end

    // frequency path
    logic        direct;
    logic [16:0] val;
    logic [16:0] fs;
    logic [15:0] bias;
    logic [15:0] gain;
    logic [9:0]  step;
    logic [27:0] freq_d;
    always_comb begin
        gain = m_bcd ? bcd_gain_freq_q : bin_gain_freq_q;
        bias = m_bcd ? bcd_bias_freq_q : bin_bias_freq_q;
        val  = {1'b0, m_bcd ? bcd_value(word_q) : word_q};
        direct = (gain == dss_pkg::SPECIAL_9999);
        unique case ({m_bcd, m_wide})
            2'b11:   fs = dss_pkg::FS_BCD4;
            2'b10:   fs = dss_pkg::FS_BCD3;
            2'b01:   fs = dss_pkg::FS_BIN16;
            default: fs = dss_pkg::FS_BIN12;
        endcase
        unique case (direct_unit_step_q)
            2'h0:    step = dss_pkg::STEP_10HZ;
            2'h1:    step = dss_pkg::STEP_1HZ;
            2'h2:    step = dss_pkg::STEP_0P1HZ;
            default: step = dss_pkg::STEP_0P01HZ;
        endcase
        if (!(m_bcd || m_bin) || force_zero_q) begin
            freq_d = 28'h0000000;
        end else if (direct) begin
            freq_d = 28'(val * step);
        end else begin
            freq_d = interp(bias, gain, val, fs);
        end
    end

    // torque path, binary only and never scaled by the unit step
    logic               trq_ok;
    logic               sign;
    logic [15:0]        mag;
    logic [16:0]        tfs;
    logic [27:0]        tpct;
    logic [9:0]         tmag;
    always_comb begin
        trq_ok = m_trq && (torque_source_select_q == dss_pkg::TRQ_SRC_DIGITAL);
        sign   = m_wide ? word_q[15] : word_q[11];
        mag    = m_wide ? {1'b0, word_q[14:0]} : {5'h00, word_q[10:0]};
        tfs    = m_wide ? dss_pkg::FS_TRQ16 : dss_pkg::FS_TRQ12;
        if (torque_gain_pct_q == dss_pkg::SPECIAL_9999) begin
            tpct = (mag > dss_pkg::TRQ_DIRECT_MAX) ? {12'h000, dss_pkg::TRQ_DIRECT_MAX}
                                                   : {12'h000, mag};
        end else begin
            tpct = interp(torque_bias_pct_q, torque_gain_pct_q, {1'b0, mag}, tfs);
        end
        tmag = tpct[9:0];
    end

    // outputs
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            freq_q          <= 28'h0000000;
            torque_q        <= 10'sh000;
            torque_valid_q  <= 1'b0;
            digital_valid_q <= 1'b0;
            comp_q          <= 1'b0;
        end else begin
            freq_q          <= freq_d;
            torque_valid_q  <= trq_ok;
            digital_valid_q <= m_bcd || m_bin;
            comp_q          <= m_comp;
            if (!trq_ok) begin
                torque_q <= 10'sh000;
            end else if (sign) begin
                torque_q <= -$signed(tmag);
            end else begin
                torque_q <= $signed(tmag);
            end
        end
    end

    // frequency source ranking
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            source_q <= dss_pkg::SRC_NONE;
        end else if (src_req.jog_request) begin
            source_q <= dss_pkg::SRC_JOG;
        end else if (src_req.stop_on_contact_req) begin
            source_q <= dss_pkg::SRC_STOP_CONT;
        end else if (src_req.multi_speed_req) begin
            source_q <= dss_pkg::SRC_MULTI_SPEED;
        end else if (src_req.pid_select_line) begin
            source_q <= dss_pkg::SRC_PID;
        end else if (src_req.current_input_select) begin
            source_q <= dss_pkg::SRC_CURRENT;
        end else if (src_req.pulse_train_req) begin
            source_q <= dss_pkg::SRC_PULSE;
        end else if (m_bcd || m_bin) begin
            source_q <= dss_pkg::SRC_DIGITAL;
        end else if (src_req.voltage_input_req) begin
            source_q <= dss_pkg::SRC_VOLTAGE;
        end else begin
            source_q <= dss_pkg::SRC_NONE;
        end
    end

    // read data, one cycle after the strobe only
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= 32'h00000000;
        end else if (bus_req.rd) begin
            unique case (bus_req.addr)
                dss_pkg::ADDR_BCD_BIAS:   rdata_q <= {16'h0000, bcd_bias_freq_q};
                dss_pkg::ADDR_BCD_GAIN:   rdata_q <= {16'h0000, bcd_gain_freq_q};
                dss_pkg::ADDR_BIN_BIAS:   rdata_q <= {16'h0000, bin_bias_freq_q};
                dss_pkg::ADDR_BIN_GAIN:   rdata_q <= {16'h0000, bin_gain_freq_q};
                dss_pkg::ADDR_METHOD:     rdata_q <= {16'h0000, input_method_select_q};
                dss_pkg::ADDR_UNIT_STEP:  rdata_q <= {30'h00000000, direct_unit_step_q};
                dss_pkg::ADDR_TRQ_BIAS:   rdata_q <= {16'h0000, torque_bias_pct_q};
                dss_pkg::ADDR_TRQ_GAIN:   rdata_q <= {16'h0000, torque_gain_pct_q};
                dss_pkg::ADDR_TRQ_SOURCE: rdata_q <= {29'h00000000, torque_source_select_q};
                dss_pkg::ADDR_FREQ_STAT:  rdata_q <= {4'h0, freq_q};
                dss_pkg::ADDR_TRQ_STAT:   rdata_q <= {{22{torque_q[9]}}, torque_q};
                dss_pkg::ADDR_STATUS:     rdata_q <= {source_q, word_q, 3'h0, reject_q,
                                                      force_zero_q, comp_q, torque_valid_q,
                                                      digital_valid_q};
                default:                  rdata_q <= 32'h00000000;
            endcase
        end else begin
            rdata_q <= 32'h00000000;
        end
    end

    assign rdata              = rdata_q;
    assign freq_setpoint      = freq_q;
    assign torque_cmd         = torque_q;
    assign torque_valid       = torque_valid_q;
    assign digital_valid      = digital_valid_q;
    assign analog_comp_enable = comp_q;
    assign active_source      = source_q;

endmodule : dss_scaler

`default_nettype wire

//--- pkg/dss_pkg.sv
// constants, register map and carrier types for the digital setpoint scaler
package dss_pkg;

    // register byte offsets
    localparam logic [7:0] ADDR_BCD_BIAS    = 8'h00;
    localparam logic [7:0] ADDR_BCD_GAIN    = 8'h04;
    localparam logic [7:0] ADDR_BIN_BIAS    = 8'h08;
    localparam logic [7:0] ADDR_BIN_GAIN    = 8'h0c;
    localparam logic [7:0] ADDR_METHOD      = 8'h10;
    localparam logic [7:0] ADDR_UNIT_STEP   = 8'h14;
    localparam logic [7:0] ADDR_TRQ_BIAS    = 8'h18;
    localparam logic [7:0] ADDR_TRQ_GAIN    = 8'h1c;
    localparam logic [7:0] ADDR_TRQ_SOURCE  = 8'h20;
    localparam logic [7:0] ADDR_FREQ_STAT   = 8'h24;
    localparam logic [7:0] ADDR_TRQ_STAT    = 8'h28;
    localparam logic [7:0] ADDR_STATUS      = 8'h2c;

    // special setting meaning direct mode or no function
    localparam logic [15:0] SPECIAL_9999    = 16'h270f;

    // reset values, frequencies in 0.01 Hz, torque in percent
    localparam logic [15:0] RST_BIAS_FREQ   = 16'h0000;
    localparam logic [15:0] RST_GAIN_FREQ   = 16'h1770;
    localparam logic [15:0] RST_METHOD      = 16'h270f;
    localparam logic [1:0]  RST_UNIT_STEP   = 2'h1;
    localparam logic [15:0] RST_TRQ_BIAS    = 16'h0000;
    localparam logic [15:0] RST_TRQ_GAIN    = 16'h0096;
    localparam logic [2:0]  RST_TRQ_SOURCE  = 3'h0;

    // input method codes
    localparam logic [15:0] METH_BCD3       = 16'h0000;
    localparam logic [15:0] METH_BIN12      = 16'h0001;
    localparam logic [15:0] METH_BCD3_COMP  = 16'h0002;
    localparam logic [15:0] METH_BIN12_COMP = 16'h0003;
    localparam logic [15:0] METH_TRQ12      = 16'h0004;
    localparam logic [15:0] METH_BCD4       = 16'h000a;
    localparam logic [15:0] METH_BIN16      = 16'h000b;
    localparam logic [15:0] METH_BCD4_COMP  = 16'h000c;
    localparam logic [15:0] METH_BIN16_COMP = 16'h000d;
    localparam logic [15:0] METH_TRQ16      = 16'h000e;
    localparam logic [2:0]  TRQ_SRC_DIGITAL = 3'h4;

    // full-scale input values
    localparam logic [16:0] FS_BCD3         = 17'h003e7;
    localparam logic [16:0] FS_BCD4         = 17'h0270f;
    localparam logic [16:0] FS_BIN12        = 17'h00fff;
    localparam logic [16:0] FS_BIN16        = 17'h0ffff;
    localparam logic [16:0] FS_TRQ12        = 17'h007ff;
    localparam logic [16:0] FS_TRQ16        = 17'h07fff;
    localparam logic [15:0] TRQ_DIRECT_MAX  = 16'h0190;

    // direct-mode multipliers to 0.01 Hz units, by unit step code
    localparam logic [9:0]  STEP_10HZ       = 10'h3e8;
    localparam logic [9:0]  STEP_1HZ        = 10'h064;
    localparam logic [9:0]  STEP_0P1HZ      = 10'h00a;
    localparam logic [9:0]  STEP_0P01HZ     = 10'h001;

    // frequency source codes: SRC_NONE all zero, the rest one-hot, highest priority first
    localparam logic [7:0]  SRC_NONE        = 8'h00;
    localparam logic [7:0]  SRC_JOG         = 8'h01;
    localparam logic [7:0]  SRC_STOP_CONT   = 8'h02;
    localparam logic [7:0]  SRC_MULTI_SPEED = 8'h04;
    localparam logic [7:0]  SRC_PID         = 8'h08;
    localparam logic [7:0]  SRC_CURRENT     = 8'h10;
    localparam logic [7:0]  SRC_PULSE       = 8'h20;
    localparam logic [7:0]  SRC_DIGITAL     = 8'h40;
    localparam logic [7:0]  SRC_VOLTAGE     = 8'h80;

    typedef struct packed {
        logic jog_request;
        logic stop_on_contact_req;
        logic multi_speed_req;
        logic pid_select_line;
        logic current_input_select;
        logic pulse_train_req;
        logic voltage_input_req;
    } dss_src_req_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } dss_bus_req_t;

endpackage : dss_pkg

//--- bench/dss_word_src.sv
// far-side controller model: drives the parallel setpoint word and source requests
`timescale 1ns/1ps
`default_nettype none

module dss_word_src (
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    input  wire logic [15:0]           word_cmd,
    input  wire dss_pkg::dss_src_req_t src_cmd,
    output var  logic [15:0]           lines,
    output var  dss_pkg::dss_src_req_t src_out
);
    // outside equipment switches its lines just after an edge, never mid-cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lines   <= 16'h0000;
            src_out <= '0;
        end else begin
            lines   <= word_cmd;
            src_out <= src_cmd;
        end
    end
endmodule : dss_word_src

`default_nettype wire

//--- bench/dss_scaler_props.sv
// concurrent checks on the setpoint scaler ports
`timescale 1ns/1ps
`default_nettype none

module dss_scaler_props (
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    input  wire dss_pkg::dss_bus_req_t bus_req,
    input  wire logic [31:0]           rdata,
    input  wire dss_pkg::dss_src_req_t src_req,
    input  wire logic signed [9:0]     torque_cmd,
    input  wire logic                  torque_valid,
    input  wire logic                  digital_valid,
    input  wire logic                  analog_comp_enable,
    input  wire logic [7:0]            active_source
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    sequence s_wr_src;
        bus_req.wr && bus_req.addr == dss_pkg::ADDR_TRQ_SOURCE;
    endsequence
    sequence s_rd_src;
        bus_req.rd && bus_req.addr == dss_pkg::ADDR_TRQ_SOURCE;
    endsequence

    AST_TRQ_OFF_ZERO: assert property (!torque_valid |-> torque_cmd == 10'h000)
        else $error("torque command not zero while torque input unselected");
    AST_TRQ_LIMIT: assert property ((torque_cmd[9] ? -torque_cmd : torque_cmd) <= 10'h190)
        else $error("torque command beyond 400 percent");
    AST_SRC_ONEHOT: assert property ($onehot0(active_source))
        else $error("more than one frequency source active");
    AST_JOG_WINS: assert property (src_req.jog_request [*3] |-> active_source == 8'h01)
        else $error("jog request did not take the setpoint");
    AST_VOLT_IGNORED: assert property (digital_valid [*2] |-> active_source != 8'h80)
        else $error("voltage input chosen while digital word valid");
    AST_TRQ_NOT_FREQ: assert property (torque_valid |-> !digital_valid)
        else $error("torque word also treated as frequency word");
    AST_COMP_NEEDS_DIG: assert property (analog_comp_enable |-> digital_valid)
        else $error("compensation enabled without a digital frequency method");
    AST_RDATA_IDLE: assert property (!$past(bus_req.rd) |-> rdata == 32'h0)
        else $error("read data present without a read");
    AST_UNMAPPED_READ: assert property (bus_req.rd && bus_req.addr > 8'h2c |=> rdata == 32'h0)
        else $error("unmapped read returned data");
    AST_SRC_READBACK: assert property (s_wr_src ##1 s_rd_src |=>
                                       rdata == {29'h0, $past(bus_req.wdata[2:0], 2)})
        else $error("torque source setting not read back");
endmodule : dss_scaler_props

bind dss_scaler dss_scaler_props u_props (
    .clk                (clk),
    .arst_n             (arst_n),
    .bus_req            (bus_req),
    .rdata              (rdata),
    .src_req            (src_req),
    .torque_cmd         (torque_cmd),
    .torque_valid       (torque_valid),
    .digital_valid      (digital_valid),
    .analog_comp_enable (analog_comp_enable),
    .active_source      (active_source)
);

`default_nettype wire

//--- bench/tb_digital_setpoint_scaler.sv
// self-checking bench for the setpoint scaler
`timescale 1ns/1ps
`default_nettype none

module tb_digital_setpoint_scaler;
    logic                  clk;
    logic                  arst_n;
    dss_pkg::dss_bus_req_t bus_req;
    logic [31:0]           rdata;
    logic [15:0]           lines;
    logic [15:0]           word_cmd;
    dss_pkg::dss_src_req_t src_req;
    dss_pkg::dss_src_req_t src_cmd;
    logic [27:0]           freq_setpoint;
    logic signed [9:0]     torque_cmd;
    logic                  torque_valid;
    logic                  digital_valid;
    logic                  analog_comp_enable;
    logic [7:0]            active_source;
    int                    failures;
    int                    n_compared;
    int                    cycles;
    int                    mult [4] = '{1000, 100, 10, 1};

    dss_word_src u_src (.clk(clk), .arst_n(arst_n), .word_cmd(word_cmd), .src_cmd(src_cmd),
                        .lines(lines), .src_out(src_req));
    dss_scaler u_dut (.clk(clk), .arst_n(arst_n), .bus_req(bus_req), .rdata(rdata),
                      .setpoint_input_lines(lines), .src_req(src_req),
                      .freq_setpoint(freq_setpoint), .torque_cmd(torque_cmd),
                      .torque_valid(torque_valid), .digital_valid(digital_valid),
                      .analog_comp_enable(analog_comp_enable), .active_source(active_source));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1 check("rdata", rdata, e);
    endtask : rd

    // write immediately followed by a read of the same place
    task automatic wr_rd(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1 check("readback", rdata, d);
    endtask : wr_rd

    // model adds one edge, scaler two more; one spare edge of margin
    task automatic setw(input logic [15:0] w);
        @(posedge clk);
        word_cmd <= w;
        repeat (4) @(posedge clk);
        #1;
    endtask : setw

    task automatic fq(input logic [15:0] w, input logic [31:0] e);
        setw(w);
        check("freq_setpoint", {4'h0, freq_setpoint}, e);
    endtask : fq

    task automatic tq(input logic [15:0] w, input logic signed [9:0] e);
        setw(w);
        check("torque_cmd", {22'h0, torque_cmd}, {22'h0, e});
    endtask : tq

    task automatic give_verdict;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            give_verdict();
        end
    end

    initial begin
        arst_n = 1'b0;
        bus_req = '0;
        word_cmd = 16'h0000;
        src_cmd = '0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        rd(dss_pkg::ADDR_BCD_GAIN, 32'h1770);
        rd(dss_pkg::ADDR_METHOD, 32'h270f);
        rd(dss_pkg::ADDR_UNIT_STEP, 32'h1);
        rd(dss_pkg::ADDR_TRQ_GAIN, 32'h96);
        rd(8'h40, 32'h0);
        wr(dss_pkg::ADDR_METHOD, 32'h0b);
        fq(16'h0000, 32'h0);
        fq(16'hffff, 32'h1770);
        fq(16'h8000, 32'hbb8);
        wr(dss_pkg::ADDR_BIN_BIAS, 32'h3e8);
        fq(16'h0000, 32'h3e8);
        wr(dss_pkg::ADDR_BIN_GAIN, 32'h270f);
        for (int i = 0; i < 4; i++) begin
            wr(dss_pkg::ADDR_UNIT_STEP, 32'(i));
            fq(16'h0100, 32'(256 * mult[i]));
        end
        wr(dss_pkg::ADDR_BIN_GAIN, 32'h1770);
        fq(16'hffff, 32'h1770);
        wr(dss_pkg::ADDR_METHOD, 32'h01);
        wr(dss_pkg::ADDR_BIN_GAIN, 32'h270f);
        wr(dss_pkg::ADDR_UNIT_STEP, 32'h1);
        fq(16'hf100, 32'h6400);
        wr(dss_pkg::ADDR_METHOD, 32'h0a);
        wr(dss_pkg::ADDR_BCD_GAIN, 32'h270f);
        fq(16'h0111, 32'h2b5c);
        fq(16'h01a1, 32'h2b5c);
        rd(dss_pkg::ADDR_FREQ_STAT, 32'h2b5c);
        rd(dss_pkg::ADDR_STATUS, 32'h40011111);
        wr(dss_pkg::ADDR_METHOD, 32'h0b);
        fq(16'h00a0, 32'h3e80);
        wr(dss_pkg::ADDR_METHOD, 32'h0a);
        fq(16'h00a0, 32'h0);
        // three-digit bcd, scaled: upper lines masked, full scale 999
        wr(dss_pkg::ADDR_METHOD, 32'h0);
        wr(dss_pkg::ADDR_BCD_GAIN, 32'h1770);
        wr(dss_pkg::ADDR_BCD_BIAS, 32'h64);
        fq(16'hf999, 32'h1770);
        fq(16'h0000, 32'h64);
        fq(16'h0500, 32'hbec);
        wr(dss_pkg::ADDR_METHOD, 32'h0c);
        fq(16'h0000, 32'h64);
        check("analog_comp_enable", {31'h0, analog_comp_enable}, 32'h1);
        check("digital_valid", {31'h0, digital_valid}, 32'h1);
        // request sets narrow from the top; the highest left set must win, and the digital word beats a lone voltage request
        for (int k = 6; k >= 0; k--) begin
            @(posedge clk);
            src_cmd <= 7'h7f >> (6 - k);
            setw(16'h0111);
            check("active_source", {24'h0, active_source},
                  {24'h0, (k > 0) ? (8'h01 << (6 - k)) : dss_pkg::SRC_DIGITAL});
        end
        wr(dss_pkg::ADDR_METHOD, 32'h270f);
        setw(16'h0111);
        check("active_source", {24'h0, active_source}, 32'h80);
        check("analog_comp_enable", {31'h0, analog_comp_enable}, 32'h0);
        check("digital_valid", {31'h0, digital_valid}, 32'h0);
        src_cmd <= '0;
        wr(dss_pkg::ADDR_METHOD, 32'h0e);
        wr_rd(dss_pkg::ADDR_TRQ_SOURCE, 32'h4);
        tq(16'h7fff, 10'sh96);
        check("torque_valid", {31'h0, torque_valid}, 32'h1);
        tq(16'h0000, 10'sh0);
        tq(16'hffff, -10'sh96);
        rd(dss_pkg::ADDR_TRQ_STAT, 32'hffffff6a);
        wr(dss_pkg::ADDR_UNIT_STEP, 32'h0);
        tq(16'h7fff, 10'sh96);
        wr(dss_pkg::ADDR_TRQ_GAIN, 32'h270f);
        tq(16'h0064, 10'sh64);
        tq(16'h0300, 10'sh190);
        tq(16'h8300, -10'sh190);
        wr(dss_pkg::ADDR_TRQ_GAIN, 32'h96);
        wr(dss_pkg::ADDR_METHOD, 32'h04);
        tq(16'hf7ff, 10'sh96);
        tq(16'h0fff, -10'sh96);
        wr(dss_pkg::ADDR_TRQ_BIAS, 32'h32);
        tq(16'h0000, 10'sh32);
        wr(dss_pkg::ADDR_TRQ_SOURCE, 32'h0);
        tq(16'h07ff, 10'sh0);
        check("torque_valid", {31'h0, torque_valid}, 32'h0);
        give_verdict();
    end
endmodule : tb_digital_setpoint_scaler

`default_nettype wire
